// ### inc/tcu_pkg.sv
/*
 Package for the 16-bit timer/counter with input capture: register
 locations, control field positions, mode codes and fixed top values.
 Assumes an 8-bit register port with one-cycle read and write strobes.
*/
package tcu_pkg;
	// Register locations on the 8-bit port
	localparam logic [3:0] ADDR_CTRL_A = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B = 4'h1;
	localparam logic [3:0] ADDR_CNT_LO = 4'h2;
	localparam logic [3:0] ADDR_CNT_HI = 4'h3;
	localparam logic [3:0] ADDR_CAP_LO = 4'h4;
	localparam logic [3:0] ADDR_CAP_HI = 4'h5;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
	localparam logic [3:0] ADDR_IRQ_FLAG = 4'h7;
	// control_reg_a: waveform_mode[1:0] in bits 1:0
	localparam int CA_WGM_LSB = 0;
	// control_reg_b fields
	localparam int CB_CS_LSB = 0;
	localparam int CB_WGM_LSB = 3;
	localparam int CB_EDGE_BIT = 6;
	localparam int CB_FILT_BIT = 7;
	// Flag and mask bit positions
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CAP_BIT = 5;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] BOTTOM_VAL = 16'h0000;
	localparam logic [15:0] MAX_VAL = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam int FILTER_SAMPLES = 4;
	localparam int SYNC_STAGES = 2;
	localparam logic [2:0] CS_STOPPED = 3'h0;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	typedef enum logic [1:0] {
		TCU_TOP_MAX,
		TCU_TOP_FIXED,
		TCU_TOP_CAPTURE,
		TCU_TOP_COMPARE
	} tcu_topsrc_e;

	// Host register port request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} tcu_req_s;

	// Counter indications to flag logic
	typedef struct packed {
		logic at_top;
		logic at_bottom;
		logic at_max;
	} tcu_cnt_ind_s;
endpackage

// ### tb/tcu_host_model.sv
/*
 Host core model: byte accesses on the register port, 16-bit helpers.
 Assumes every task is entered just after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module tcu_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] host_rdata,
	output var tcu_pkg::tcu_req_s host_req
);
	// Extra idle cycles between bytes; zero gives back-to-back wr16 writes, rd16 reads keep one idle
	int gap = 0;
	initial host_req = '0;
	task automatic acc(input logic rd, input logic [3:0] a, input logic [7:0] d);
		host_req <= '{rd: rd, wr: !rd, addr: a, wdata: d};
		@(posedge sys_clk);
	endtask
	task automatic idle();
		host_req <= '0;
		@(posedge sys_clk);
	endtask
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		acc(1'b0, a, d);
		idle();
	endtask
	task automatic rd8(input logic [3:0] a, output logic [7:0] d);
		acc(1'b1, a, 8'h00);
		idle();
		d = host_rdata;
	endtask
	task automatic wr16(input logic [3:0] hi, input logic [15:0] v);
		acc(1'b0, hi, v[15:8]);
		repeat (gap) idle();
		acc(1'b0, hi - 4'h1, v[7:0]);
		idle();
	endtask
	task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
		rd8(lo, v[7:0]);
		repeat (gap) idle();
		rd8(lo + 4'h1, v[15:8]);
	endtask
endmodule
`default_nettype wire

// ### tb/tcu_timer16_assertions.sv
/*
 Port checker for tcu_timer16: staging byte, capture flag, overflow ack.
 Assumes binding to tcu_timer16 and capture latency below sixteen cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tcu_timer16_chk (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire tcu_pkg::tcu_req_s host_req,
	input wire logic [7:0] host_rdata,
	input wire logic [6:0] presc_tick,
	input wire logic ext_clk_in,
	input wire logic capture_pin,
	input wire logic comparator_output,
	input wire logic capture_src_sel,
	input wire logic overflow_ack,
	input wire logic capture_ack,
	input wire logic overflow_irq,
	input wire logic capture_irq,
	input wire logic at_bottom
);
	logic [3:0] in_r;
	logic [7:0] quiet_r;
	logic quiet;
	logic wr_flag;
	// Quiet means no input change that could still become a capture or count
	assign quiet = quiet_r >= 8'h10;
	assign wr_flag = host_req.wr && host_req.addr == tcu_pkg::ADDR_IRQ_FLAG;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			in_r <= 4'h0;
			quiet_r <= 8'h00;
		end else begin
			in_r <= {ext_clk_in, capture_pin, comparator_output, capture_src_sel};
			if (in_r != {ext_clk_in, capture_pin, comparator_output, capture_src_sel})
				quiet_r <= 8'h00;
			else if (quiet_r != 8'hff)
				quiet_r <= quiet_r + 8'h01;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence hi_wr_s;
		host_req.wr && host_req.addr == tcu_pkg::ADDR_CNT_HI;
	endsequence
	sequence hi_rd_s;
		host_req.rd && host_req.addr == tcu_pkg::ADDR_CNT_HI;
	endsequence
	sequence lo_wr_s;
		host_req.wr && host_req.addr == tcu_pkg::ADDR_CNT_LO;
	endsequence
	stage_read_a: assert property (hi_wr_s ##1 hi_rd_s |=>
		host_rdata == $past(host_req.wdata, 2)) else $error("staging byte not returned");
	low_write_a: assert property (hi_wr_s ##1 lo_wr_s |=> at_bottom ==
		($past(host_req.wdata, 2) == 8'h00 && $past(host_req.wdata) == 8'h00))
		else $error("low write did not load full count");
	rdata_hold_a: assert property (!host_req.rd |=> $stable(host_rdata))
		else $error("read data changed without read");
	cap_ack_a: assert property (capture_ack && quiet |=> !capture_irq)
		else $error("capture ack did not clear flag");
	cap_clear_a: assert property (wr_flag && host_req.wdata[tcu_pkg::FLAG_CAP_BIT] && quiet
		|=> !capture_irq) else $error("write one did not clear capture flag");
	cap_keep_a: assert property (wr_flag && !host_req.wdata[tcu_pkg::FLAG_CAP_BIT]
		&& capture_irq && !capture_ack |=> capture_irq) else $error("write zero cleared flag");
	cap_cause_a: assert property (!host_req.wr ##1 $rose(capture_irq) |-> !quiet)
		else $error("capture without input change");
	ovf_ack_a: assert property (overflow_ack && !(|presc_tick) && quiet |=>
		!overflow_irq) else $error("overflow ack did not clear flag");
	bottom_hold_a: assert property (!(|presc_tick) && !host_req.wr && quiet |=>
		$stable(at_bottom)) else $error("count moved without tick");
endmodule
`default_nettype wire

// ### tb/test_tcu_timer16.sv
/*
 Self-checking bench for tcu_timer16 with the host model on the port.
 Assumes the checker module and host model are compiled beforehand.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_tcu_timer16;
	logic sys_clk, rstn, ext_clk_in, capture_pin, comparator_output, capture_src_sel;
	logic overflow_ack, capture_ack, overflow_irq, capture_irq, at_top, at_bottom;
	logic [6:0] presc_tick;
	logic [7:0] host_rdata;
	tcu_pkg::tcu_req_s host_req;
	int n_fail = 0;
	int cmp_count = 0;
	tcu_host_model host_u (.sys_clk(sys_clk), .host_rdata(host_rdata), .host_req(host_req));
	tcu_timer16 dut_u (.sys_clk(sys_clk), .rstn(rstn), .host_req(host_req),
		.host_rdata(host_rdata), .presc_tick(presc_tick), .ext_clk_in(ext_clk_in),
		.capture_pin(capture_pin), .comparator_output(comparator_output),
		.capture_src_sel(capture_src_sel), .compare_top(16'h0000),
		.overflow_ack(overflow_ack), .capture_ack(capture_ack), .overflow_irq(overflow_irq),
		.capture_irq(capture_irq), .at_top(at_top), .at_bottom(at_bottom));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tick(input int n, input logic [6:0] m);
		repeat (n) begin
			@(posedge sys_clk);
			presc_tick <= m;
			@(posedge sys_clk);
			presc_tick <= 7'h00;
		end
	endtask
	// Bounded wait for the capture request; latency counted from the call
	task automatic wait_cap(output int lat);
		lat = 0;
		while (capture_irq !== 1'b1 && lat < 40) begin
			@(posedge sys_clk);
			lat++;
		end
	endtask
	task automatic t_stage();
		logic [7:0] b;
		host_u.acc(1'b0, tcu_pkg::ADDR_CNT_HI, 8'ha5);
		host_u.acc(1'b1, tcu_pkg::ADDR_CNT_HI, 8'h00);
		host_u.idle();
		`CHECK(host_rdata, 8'ha5)
		host_u.rd8(4'hf, b);
		`CHECK(b, 8'h00)
	endtask
	task automatic t_count();
		logic [15:0] v;
		host_u.wr8(tcu_pkg::ADDR_CTRL_B, 8'h00);
		host_u.wr16(tcu_pkg::ADDR_CNT_HI, 16'h01ff);
		tick(3, 7'h02);
		host_u.rd16(tcu_pkg::ADDR_CNT_LO, v);
		`CHECK(v, 16'h01ff)
		host_u.wr8(tcu_pkg::ADDR_CTRL_B, 8'h01);
		tick(5, 7'h02);
		tick(4, 7'h04);
		host_u.gap = 2;
		host_u.rd16(tcu_pkg::ADDR_CNT_LO, v);
		host_u.gap = 0;
		`CHECK(v, 16'h0204)
		presc_tick <= 7'h02;
		host_u.wr16(tcu_pkg::ADDR_CNT_HI, 16'h8000);
		presc_tick <= 7'h00;
		host_u.rd16(tcu_pkg::ADDR_CNT_LO, v);
		`CHECK(v, 16'h8001)
		host_u.wr8(tcu_pkg::ADDR_CTRL_B, 8'h07);
		repeat (6) begin
			repeat (4) @(posedge sys_clk);
			ext_clk_in <= ~ext_clk_in;
		end
		repeat (8) @(posedge sys_clk);
		host_u.wr8(tcu_pkg::ADDR_CTRL_B, 8'h00);
		host_u.rd16(tcu_pkg::ADDR_CNT_LO, v);
		`CHECK(v, 16'h8004)
	endtask
	task automatic t_ovf();
		host_u.wr8(tcu_pkg::ADDR_IRQ_MASK, 8'h21);
		host_u.wr8(tcu_pkg::ADDR_CTRL_B, 8'h01);
		host_u.wr16(tcu_pkg::ADDR_CNT_HI, 16'hfffe);
		tick(1, 7'h02);
		@(posedge sys_clk);
		`CHECK(at_top, 1'b1)
		`CHECK(overflow_irq, 1'b0)
		tick(1, 7'h02);
		repeat (2) @(posedge sys_clk);
		`CHECK(overflow_irq, 1'b1)
		`CHECK(at_bottom, 1'b1)
		overflow_ack <= 1'b1;
		@(posedge sys_clk);
		overflow_ack <= 1'b0;
		repeat (2) @(posedge sys_clk);
		`CHECK(overflow_irq, 1'b0)
	endtask
	task automatic t_dual();
		logic [15:0] v;
		host_u.wr8(tcu_pkg::ADDR_CTRL_A, 8'h01);
		host_u.wr16(tcu_pkg::ADDR_CNT_HI, 16'h00fe);
		tick(3, 7'h02);
		host_u.rd16(tcu_pkg::ADDR_CNT_LO, v);
		`CHECK(v, 16'h00fd)
		host_u.wr8(tcu_pkg::ADDR_CTRL_A, 8'h00);
	endtask
	task automatic t_cap();
		logic [15:0] v;
		int lat0, lat1;
		host_u.wr8(tcu_pkg::ADDR_CTRL_B, 8'h40);
		host_u.wr16(tcu_pkg::ADDR_CNT_HI, 16'h1234);
		capture_pin <= 1'b1;
		wait_cap(lat0);
		`CHECK(capture_irq, 1'b1)
		host_u.rd16(tcu_pkg::ADDR_CAP_LO, v);
		`CHECK(v, 16'h1234)
		host_u.wr8(tcu_pkg::ADDR_IRQ_FLAG, 8'h01);
		`CHECK(capture_irq, 1'b1)
		host_u.wr8(tcu_pkg::ADDR_IRQ_FLAG, 8'h20);
		`CHECK(capture_irq, 1'b0)
		capture_pin <= 1'b0;
		wait_cap(lat1);
		`CHECK(capture_irq, 1'b0)
		host_u.wr8(tcu_pkg::ADDR_CTRL_B, 8'hc0);
		capture_pin <= 1'b1;
		repeat (3) @(posedge sys_clk);
		capture_pin <= 1'b0;
		wait_cap(lat1);
		`CHECK(capture_irq, 1'b0)
		capture_pin <= 1'b1;
		wait_cap(lat1);
		`CHECK(lat1 - lat0, 4)
		host_u.wr8(tcu_pkg::ADDR_IRQ_FLAG, 8'h20);
		capture_src_sel <= 1'b1;
		// Let the filtered level settle on the new source first
		repeat (10) @(posedge sys_clk);
		host_u.wr8(tcu_pkg::ADDR_IRQ_FLAG, 8'h20);
		comparator_output <= 1'b1;
		wait_cap(lat1);
		`CHECK(capture_irq, 1'b1)
		repeat (20) @(posedge sys_clk);
		capture_ack <= 1'b1;
		@(posedge sys_clk);
		capture_ack <= 1'b0;
		@(posedge sys_clk);
		`CHECK(capture_irq, 1'b0)
	endtask
	task automatic t_top();
		logic [15:0] v;
		int lat;
		capture_src_sel <= 1'b0;
		capture_pin <= 1'b0;
		repeat (20) @(posedge sys_clk);
		host_u.wr8(tcu_pkg::ADDR_CTRL_B, 8'h58);
		host_u.wr16(tcu_pkg::ADDR_CAP_HI, 16'h0abc);
		host_u.rd16(tcu_pkg::ADDR_CAP_LO, v);
		`CHECK(v, 16'h0abc)
		host_u.wr8(tcu_pkg::ADDR_CNT_HI, 8'h0a);
		host_u.wr8(tcu_pkg::ADDR_CNT_LO, 8'h77);
		host_u.rd16(tcu_pkg::ADDR_CNT_LO, v);
		`CHECK(v, 16'h0a77)
		capture_pin <= 1'b1;
		wait_cap(lat);
		`CHECK(capture_irq, 1'b0)
		capture_pin <= 1'b0;
		repeat (20) @(posedge sys_clk);
		host_u.wr8(tcu_pkg::ADDR_CTRL_B, 8'h40);
		host_u.wr16(tcu_pkg::ADDR_CAP_HI, 16'h5555);
		host_u.rd16(tcu_pkg::ADDR_CAP_LO, v);
		`CHECK(v, 16'h0abc)
	endtask
	initial begin
		rstn = 1'b0;
		presc_tick = 7'h00;
		ext_clk_in = 1'b0;
		capture_pin = 1'b0;
		comparator_output = 1'b0;
		capture_src_sel = 1'b0;
		overflow_ack = 1'b0;
		capture_ack = 1'b0;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		t_stage();
		t_count();
		t_ovf();
		t_dual();
		t_cap();
		t_top();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		end_of_test();
	end
endmodule
bind tcu_timer16 tcu_timer16_chk chk_u (.sys_clk(sys_clk), .rstn(rstn), .host_req(host_req),
	.host_rdata(host_rdata), .presc_tick(presc_tick), .ext_clk_in(ext_clk_in),
	.capture_pin(capture_pin), .comparator_output(comparator_output),
	.capture_src_sel(capture_src_sel), .overflow_ack(overflow_ack), .capture_ack(capture_ack),
	.overflow_irq(overflow_irq), .capture_irq(capture_irq), .at_bottom(at_bottom));
`default_nettype wire

// ### verilog/tcu_edge_detect.sv
/*
 Edge detector: one-cycle pulse on the selected edge of a synchronous
 level. Assumes the input is already in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module tcu_edge_detect (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic din,
	input wire logic rise_sel,
	output logic edge_pulse
);
	logic prev_r;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			prev_r <= 1'b0;
		else
			prev_r <= din;
	end

	assign edge_pulse = rise_sel ? (din & ~prev_r) : (~din & prev_r);
endmodule
`default_nettype wire

// ### verilog/tcu_sync_filter.sv
/*
 Capture input conditioner: two-flop synchroniser then an optional
 four-sample majority-free agreement filter on the system clock.
 Assumes the input is an asynchronous level.
*/
`timescale 1ns/1ps
`default_nettype none
module tcu_sync_filter (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic din,
	input wire logic filt_en,
	output logic dout
);
	logic meta_r;
	logic sync_r;
	// Older samples; the fourth is the current synchroniser output
	logic [tcu_pkg::FILTER_SAMPLES-2:0] hist_r;
	logic filt_r;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= din;
			sync_r <= meta_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hist_r <= '0;
			filt_r <= 1'b0;
		end else begin
			hist_r <= {hist_r[tcu_pkg::FILTER_SAMPLES-3:0], sync_r};
			// Counting sync_r itself keeps the added delay at exactly four
			if (&{hist_r, sync_r})
				filt_r <= 1'b1;
			else if (~|{hist_r, sync_r})
				filt_r <= 1'b0;
		end
	end

	assign dout = filt_en ? filt_r : sync_r;
endmodule
`default_nettype wire

// ### verilog/tcu_timer16.sv
/*
 16-bit up/down timer/counter with input capture, reached over an 8-bit
 register port with a shared high-byte staging register.
 Assumes a host that issues one-cycle rd/wr strobes synchronous to
 sys_clk, and a prescaler outside that supplies the tick enables.
*/
`timescale 1ns/1ps
`default_nettype none
module tcu_timer16 (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire tcu_pkg::tcu_req_s host_req,
	output logic [7:0] host_rdata,
	input wire logic [6:0] presc_tick,
	input wire logic ext_clk_in,
	input wire logic capture_pin,
	input wire logic comparator_output,
	input wire logic capture_src_sel,
	input wire logic [15:0] compare_top,
	input wire logic overflow_ack,
	input wire logic capture_ack,
	output logic overflow_irq,
	output logic capture_irq,
	output logic at_top,
	output logic at_bottom
);
	logic [7:0] control_reg_a_r;
	logic [7:0] control_reg_b_r;
	logic [7:0] irq_mask_r;
	logic [7:0] staging_r;
	logic [15:0] count_value_r;
	logic [15:0] count_nxt;
	logic [15:0] capture_value_r;
	logic overflow_flag_r;
	logic capture_flag_r;
	logic count_down_r;
	logic ext_meta_r;
	logic ext_sync_r;
	logic ext_prev_r;
	logic [7:0] rdata_r;
	logic [3:0] waveform_mode;
	logic [2:0] clock_source_select;
	logic capture_filter_enable;
	logic edge_rise;
	logic timer_tick;
	logic ext_edge;
	tcu_pkg::tcu_topsrc_e top_src;
	logic [15:0] top_val;
	logic pwm_dual;
	logic clear_on_top;
	tcu_pkg::tcu_cnt_ind_s ind;
	logic cap_gate;
	logic cap_raw;
	logic cap_cond;
	logic cap_edge;
	logic capture_now;
	logic ovf_set;
	logic rd_cnt_lo;
	logic wr_cnt_lo;
	logic rd_cap_lo;
	logic wr_cap_lo;
	logic wr_hi;
	logic wr_flag;
	logic mode_cap_top;

	// Mode split over both control regs
	assign waveform_mode = {control_reg_b_r[tcu_pkg::CB_WGM_LSB+:2],
		control_reg_a_r[tcu_pkg::CA_WGM_LSB+:2]};
	assign clock_source_select = control_reg_b_r[tcu_pkg::CB_CS_LSB+:3];
	assign capture_filter_enable = control_reg_b_r[tcu_pkg::CB_FILT_BIT];
	assign edge_rise = control_reg_b_r[tcu_pkg::CB_EDGE_BIT];

	assign rd_cnt_lo = host_req.rd && host_req.addr == tcu_pkg::ADDR_CNT_LO;
	assign wr_cnt_lo = host_req.wr && host_req.addr == tcu_pkg::ADDR_CNT_LO;
	assign rd_cap_lo = host_req.rd && host_req.addr == tcu_pkg::ADDR_CAP_LO;
	assign wr_cap_lo = host_req.wr && host_req.addr == tcu_pkg::ADDR_CAP_LO;
	assign wr_hi = host_req.wr && (host_req.addr == tcu_pkg::ADDR_CNT_HI ||
		host_req.addr == tcu_pkg::ADDR_CAP_HI);
	assign wr_flag = host_req.wr && host_req.addr == tcu_pkg::ADDR_IRQ_FLAG;

	// Mode decode: top source, fixed top, dual-slope and clear-on-top
	always_comb begin
		top_src = tcu_pkg::TCU_TOP_MAX;
		top_val = tcu_pkg::MAX_VAL;
		pwm_dual = 1'b0;
		clear_on_top = 1'b0;
		unique case (waveform_mode)
			4'h0: top_src = tcu_pkg::TCU_TOP_MAX;
			4'h1, 4'h5: top_src = tcu_pkg::TCU_TOP_FIXED;
			4'h2, 4'h6: top_src = tcu_pkg::TCU_TOP_FIXED;
			4'h3, 4'h7: top_src = tcu_pkg::TCU_TOP_FIXED;
			4'h4, 4'hf, 4'h9, 4'hb: top_src = tcu_pkg::TCU_TOP_COMPARE;
			4'h8, 4'ha, 4'hc, 4'he: top_src = tcu_pkg::TCU_TOP_CAPTURE;
			default: top_src = tcu_pkg::TCU_TOP_MAX;
		endcase
		unique case (top_src)
			tcu_pkg::TCU_TOP_MAX: top_val = tcu_pkg::MAX_VAL;
			tcu_pkg::TCU_TOP_FIXED: begin
				if (waveform_mode[1:0] == 2'h1)
					top_val = tcu_pkg::TOP_8BIT;
				else if (waveform_mode[1:0] == 2'h2)
					top_val = tcu_pkg::TOP_9BIT;
				else
					top_val = tcu_pkg::TOP_10BIT;
			end
			tcu_pkg::TCU_TOP_CAPTURE: top_val = capture_value_r;
			tcu_pkg::TCU_TOP_COMPARE: top_val = compare_top;
		endcase
		pwm_dual = (waveform_mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
		clear_on_top = !pwm_dual && waveform_mode != 4'h0;
	end

	assign mode_cap_top = top_src == tcu_pkg::TCU_TOP_CAPTURE;

	assign ind.at_top = count_value_r == top_val;
	assign ind.at_bottom = count_value_r == tcu_pkg::BOTTOM_VAL;
	assign ind.at_max = count_value_r == tcu_pkg::MAX_VAL;
	assign at_top = ind.at_top;
	assign at_bottom = ind.at_bottom;

	// External clock pin: synchronised then edge-detected
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
			ext_prev_r <= 1'b0;
		end else begin
			ext_meta_r <= ext_clk_in;
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
		end
	end

	always_comb begin
		ext_edge = 1'b0;
		timer_tick = 1'b0;
		if (clock_source_select == tcu_pkg::CS_EXT_FALL)
			ext_edge = ext_prev_r & ~ext_sync_r;
		else if (clock_source_select == tcu_pkg::CS_EXT_RISE)
			ext_edge = ~ext_prev_r & ext_sync_r;
		if (clock_source_select == tcu_pkg::CS_STOPPED)
			timer_tick = 1'b0;
		else if (clock_source_select >= tcu_pkg::CS_EXT_FALL)
			timer_tick = ext_edge;
		else
			timer_tick = presc_tick[clock_source_select];
	end

	// Clear, increment or decrement per mode
	always_comb begin
		count_nxt = count_value_r;
		if (pwm_dual) begin
			if (count_down_r)
				count_nxt = count_value_r - 16'h0001;
			else
				count_nxt = count_value_r + 16'h0001;
			if (ind.at_top && !ind.at_bottom)
				count_nxt = count_value_r - 16'h0001;
			else if (ind.at_bottom)
				count_nxt = count_value_r + 16'h0001;
		end else if (clear_on_top && ind.at_top) begin
			count_nxt = tcu_pkg::BOTTOM_VAL;
		end else begin
			count_nxt = count_value_r + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			count_value_r <= tcu_pkg::BOTTOM_VAL;
		else if (wr_cnt_lo)
			count_value_r <= {staging_r, host_req.wdata};
		else if (timer_tick)
			count_value_r <= count_nxt;
	end

	// Direction for dual-slope modes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			count_down_r <= 1'b0;
		else if (!pwm_dual)
			count_down_r <= 1'b0;
		else if (timer_tick && !wr_cnt_lo) begin
			if (ind.at_top)
				count_down_r <= 1'b1;
			else if (ind.at_bottom)
				count_down_r <= 1'b0;
		end
	end

	// Staging byte shared by both 16-bit registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			staging_r <= 8'h00;
		else if (rd_cnt_lo)
			staging_r <= count_value_r[15:8];
		else if (rd_cap_lo)
			staging_r <= capture_value_r[15:8];
		else if (wr_hi)
			staging_r <= host_req.wdata;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			control_reg_a_r <= tcu_pkg::CTRL_RESET;
			control_reg_b_r <= tcu_pkg::CTRL_RESET;
			irq_mask_r <= tcu_pkg::CTRL_RESET;
		end else if (host_req.wr) begin
			if (host_req.addr == tcu_pkg::ADDR_CTRL_A)
				control_reg_a_r <= host_req.wdata;
			if (host_req.addr == tcu_pkg::ADDR_CTRL_B)
				control_reg_b_r <= host_req.wdata;
			if (host_req.addr == tcu_pkg::ADDR_IRQ_MASK)
				irq_mask_r <= host_req.wdata;
		end
	end

	// Capture path; comparator is already synchronous, still conditioned
	// Pin or comparator as trigger source
	// Software-driven pin level is seen here
	assign cap_raw = capture_src_sel ? comparator_output : capture_pin;

	// Input gated off in capture-as-top modes
	assign cap_gate = !mode_cap_top;

	tcu_sync_filter u_filter (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.din(cap_raw),
		.filt_en(capture_filter_enable),
		.dout(cap_cond)
	);

	tcu_edge_detect u_edge (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.din(cap_cond),
		.rise_sel(edge_rise),
		.edge_pulse(cap_edge)
	);

	assign capture_now = cap_edge && cap_gate;

	// Host writes only in capture-as-top modes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			capture_value_r <= tcu_pkg::BOTTOM_VAL;
		else if (wr_cap_lo && mode_cap_top)
			capture_value_r <= {staging_r, host_req.wdata};
		else if (capture_now)
			capture_value_r <= count_value_r;
	end

	// Overflow at max, top or bottom per mode
	always_comb begin
		ovf_set = 1'b0;
		if (timer_tick && !wr_cnt_lo) begin
			if (pwm_dual)
				ovf_set = ind.at_bottom;
			else if (clear_on_top)
				ovf_set = ind.at_top;
			else
				ovf_set = ind.at_max;
		end
	end

	// Set wins over clear for both flags
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			overflow_flag_r <= 1'b0;
			capture_flag_r <= 1'b0;
		end else begin
			if (ovf_set)
				overflow_flag_r <= 1'b1;
			else if (overflow_ack || (wr_flag && host_req.wdata[tcu_pkg::FLAG_OVF_BIT]))
				overflow_flag_r <= 1'b0;
			if (capture_now)
				capture_flag_r <= 1'b1;
			else if (capture_ack || (wr_flag && host_req.wdata[tcu_pkg::FLAG_CAP_BIT]))
				capture_flag_r <= 1'b0;
		end
	end

	assign overflow_irq = overflow_flag_r && irq_mask_r[tcu_pkg::FLAG_OVF_BIT];
	assign capture_irq = capture_flag_r && irq_mask_r[tcu_pkg::FLAG_CAP_BIT];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			rdata_r <= 8'h00;
		else if (host_req.rd) begin
			unique case (host_req.addr)
				tcu_pkg::ADDR_CTRL_A: rdata_r <= control_reg_a_r;
				tcu_pkg::ADDR_CTRL_B: rdata_r <= control_reg_b_r;
				tcu_pkg::ADDR_CNT_LO: rdata_r <= count_value_r[7:0];
				tcu_pkg::ADDR_CNT_HI: rdata_r <= staging_r;
				tcu_pkg::ADDR_CAP_LO: rdata_r <= capture_value_r[7:0];
				tcu_pkg::ADDR_CAP_HI: rdata_r <= staging_r;
				tcu_pkg::ADDR_IRQ_MASK: rdata_r <= irq_mask_r;
				tcu_pkg::ADDR_IRQ_FLAG: rdata_r <= {2'b00, capture_flag_r, 4'h0,
					overflow_flag_r};
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	assign host_rdata = rdata_r;
endmodule
`default_nettype wire
